/* rtl/fss_pkg.sv */
// Package for the flash suspend/status/protect host controller.
// Assumes a single 40 MHz core clock and an asynchronous flash bus.
package fss_pkg;
    // Core clock period in ps
    localparam int CLK_PERIOD_PS = 25000;
    // Suspend latency in ns, as printed 15 us
    localparam int SUSPEND_MAX_NS = 15000;
    localparam int SUSPEND_CYC = (SUSPEND_MAX_NS * 1000) / CLK_PERIOD_PS;
    // Least strobe low time in ns, kept well above the noise filter
    localparam int STROBE_MIN_NS = 50;
    localparam int STROBE_CYC = (STROBE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Command address and data codes
    localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
    localparam logic [11:0] ADDR_UNLOCK2 = 12'haaa;
    localparam logic [11:0] ADDR_LOCKSTAT = 12'h080;
    localparam logic [7:0] DAT_AA = 8'haa;
    localparam logic [7:0] DAT_55 = 8'h55;
    localparam logic [7:0] DAT_SUSPEND = 8'hb0;
    localparam logic [7:0] DAT_RESUME = 8'h30;
    localparam logic [7:0] DAT_IDENT_ENTER = 8'h90;
    localparam logic [7:0] DAT_IDENT_LEAVE = 8'hf0;
    localparam logic [7:0] DAT_PREG = 8'hc0;
    localparam logic [7:0] DAT_PREG_LOCK = 8'h00;
    // Status bit positions
    localparam int POLLING_BIT = 7;
    localparam int TOGGLE_FLAG = 6;
    localparam int FAILURE_FLAG = 5;
    localparam int SUPPLY_LOW_FLAG = 3;
    localparam int ERASE_TOGGLE_FLAG = 2;
    localparam int LOCK_STATE_BIT = 1;
    // Host operations
    typedef enum logic [2:0] {
        FSS_OP_SUSPEND = 3'b000,
        FSS_OP_RESUME = 3'b001,
        FSS_OP_ID_ENTER = 3'b010,
        FSS_OP_ID_LEAVE = 3'b011,
        FSS_OP_PREG_PROG = 3'b100,
        FSS_OP_PREG_LOCK = 3'b101,
        FSS_OP_READ = 3'b110,
        FSS_OP_POLL = 3'b111
    } fss_op_e;
    // One user request
    typedef struct packed {
        fss_op_e op;
        logic [19:0] addr;
        logic [15:0] data;
    } fss_req_s;
    // Flash bus pins driven by the host
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [19:0] addr;
        logic [15:0] dq_o;
        logic dq_oe;
    } fss_bus_s;
endpackage

/* rtl/fss_host.sv */
// Host controller that writes command cycles to a parallel NOR flash and reads status.
// Assumes flash pins are sampled synchronous to i_core_clk; bus wire resolution outside.
// Function
// [RULE1] Device halts erase within 15 us
// [RULE2] No erase of other sector while suspended
// [RULE3] Suspend is one cycle, address ignored
// [RULE4] Resume is one bus cycle
// [RULE5] Chip erase suspends with same sequence
// [RULE6] Device halts program within 15 us
// [RULE7] One suspend code, one resume code
// [RULE8] Identification mode returns identical codes
// [RULE9] 128-bit register, factory half fixed
// [RULE10] User half written by four-cycle command
// [RULE11] Lock uses four cycles, lock bit zero
// [RULE12] Address 80H lock bit: zero locked
// [RULE13] Locked user half refuses programming
// [RULE14] Read register in ident mode, then exit
// [RULE15] Busy line low during internal cycles
// [RULE16] No program with output enable low
// [RULE17] Short strobe pulses are ignored
// [RULE18] Program status bits per configuration
// [RULE19] Erase status bits, suspended reads
// [RULE20] Failure flag on timeout or protection
// [RULE21] Supply-low flag on weak supply
// [RULE22] Recheck polling after failure flag seen
// [RULE23] Config 01 needs exit after success
// [RULE24] After failure, exit returns read mode
`timescale 1ns/1ps
module fss_host
    import fss_pkg::*;
#(
    parameter int STROBE_CYCLES = STROBE_CYC,
    parameter int SUSPEND_CYCLES = SUSPEND_CYC
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // User request port
    input wire logic i_req_valid,
    input wire fss_req_s i_req,
    output logic o_req_ready,
    output logic o_done,
    output logic [15:0] o_rdata,
    output logic o_fail,
    output logic o_supply_low,
    output logic o_locked,
    output logic o_erase_blocked,
    // User side state inputs
    input wire logic i_erase_active,
    // Flash pins
    output fss_bus_s o_bus,
    input wire logic [15:0] i_dq,
    input wire logic i_rdy_busy
);
    initial begin
        if (STROBE_CYCLES < 1 || STROBE_CYCLES > 255) begin
            $error("STROBE_CYCLES out of range");
        end
        if (SUSPEND_CYCLES < 1 || SUSPEND_CYCLES > 65535) begin
            $error("SUSPEND_CYCLES out of range");
        end
    end

    // Controller states
    typedef enum logic [2:0] {
        FSS_IDLE = 3'b000,
        FSS_WSETUP = 3'b001,
        FSS_WPULSE = 3'b010,
        FSS_WHOLD = 3'b011,
        FSS_RPULSE = 3'b100,
        FSS_SWAIT = 3'b101,
        FSS_FINISH = 3'b110
    } fss_state_e;

    fss_state_e state_ff, nxt_state;
    fss_req_s req_ff; // Latched request
    logic [2:0] cyc_ff; // Bus cycle index within a command
    logic [15:0] cnt_ff; // Strobe and wait counter
    logic [15:0] rdata_ff; // Captured read data
    logic fail_ff, supply_ff, locked_ff, done_ff;
    logic susp_ff; // Host believes an operation is suspended
    logic [15:0] poll_prev_ff; // Previous status read, stored on each poll

    // Number of bus cycles per operation
    wire logic [2:0] n_cycles;
    assign n_cycles = (req_ff.op == FSS_OP_SUSPEND || req_ff.op == FSS_OP_RESUME) ? 3'd1 :
        (req_ff.op == FSS_OP_ID_ENTER || req_ff.op == FSS_OP_ID_LEAVE) ? 3'd3 :
        (req_ff.op == FSS_OP_PREG_PROG || req_ff.op == FSS_OP_PREG_LOCK) ? 3'd4 : 3'd0;
    wire logic is_write_op;
    assign is_write_op = (n_cycles != 3'd0);

    // Address and data of the current command cycle
    logic [11:0] cyc_addr;
    logic [7:0] cyc_data;
    always_comb begin
        cyc_addr = ADDR_UNLOCK1;
        cyc_data = DAT_AA;
        if (n_cycles == 3'd1) begin
            // Single cycle, address unused by the device  see [RULE3] see [RULE4] see [RULE7]
            cyc_addr = 12'h000;
            cyc_data = (req_ff.op == FSS_OP_SUSPEND) ? DAT_SUSPEND : DAT_RESUME;
        end else begin
            case (cyc_ff)
                3'd0: begin
                    cyc_addr = ADDR_UNLOCK1;
                    cyc_data = DAT_AA;
                end
                3'd1: begin
                    cyc_addr = ADDR_UNLOCK2;
                    cyc_data = DAT_55;
                end
                3'd2: begin
                    cyc_addr = ADDR_UNLOCK1;
                    cyc_data = (req_ff.op == FSS_OP_ID_ENTER) ? DAT_IDENT_ENTER :
                        (req_ff.op == FSS_OP_ID_LEAVE) ? DAT_IDENT_LEAVE : DAT_PREG;
                end
                3'd3: begin
                    // Lock clears the lock bit; program sends user data  see [RULE10] see [RULE11]
                    cyc_addr = (req_ff.op == FSS_OP_PREG_LOCK) ? ADDR_LOCKSTAT : req_ff.addr[11:0];
                    cyc_data = (req_ff.op == FSS_OP_PREG_LOCK) ? DAT_PREG_LOCK : req_ff.data[7:0];
                end
                default: begin
                    cyc_addr = ADDR_UNLOCK1;
                    cyc_data = DAT_AA;
                end
            endcase
        end
    end

    // Refuse user-half program requests at the port while locked; flag a user erase while suspended
    wire logic preg_refused;
    assign preg_refused = (i_req.op == FSS_OP_PREG_PROG) && locked_ff; // see [RULE13]
    assign o_erase_blocked = susp_ff && i_erase_active; // see [RULE2]
    assign o_req_ready = (state_ff == FSS_IDLE);
    wire logic req_take;
    assign req_take = i_req_valid && o_req_ready && !preg_refused;

    // Next state
    wire logic strobe_done;
    assign strobe_done = (cnt_ff >= 16'(STROBE_CYCLES - 1));
    wire logic last_cycle;
    assign last_cycle = (cyc_ff == n_cycles - 3'd1);
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            FSS_IDLE: begin
                if (req_take) begin
                    nxt_state = FSS_WSETUP;
                end
            end
            FSS_WSETUP: begin
                nxt_state = is_write_op ? FSS_WPULSE : FSS_RPULSE;
            end
            FSS_WPULSE: begin
                if (strobe_done) begin
                    nxt_state = FSS_WHOLD;
                end
            end
            FSS_WHOLD: begin
                if (!last_cycle) begin
                    nxt_state = FSS_WSETUP;
                end else if (req_ff.op == FSS_OP_SUSPEND) begin
                    nxt_state = FSS_SWAIT;
                end else begin
                    nxt_state = FSS_FINISH;
                end
            end
            FSS_RPULSE: begin
                if (strobe_done) begin
                    nxt_state = FSS_FINISH;
                end
            end
            FSS_SWAIT: begin
                // Allow the device its suspend latency  see [RULE1] see [RULE6]
                if (cnt_ff >= 16'(SUSPEND_CYCLES - 1)) begin
                    nxt_state = FSS_FINISH;
                end
            end
            FSS_FINISH: begin
                nxt_state = FSS_IDLE;
            end
            default: begin
                nxt_state = FSS_IDLE;
            end
        endcase
    end

    // State and counters
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_ff <= FSS_IDLE;
            cnt_ff <= 16'h0000;
            cyc_ff <= 3'h0;
            req_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= (nxt_state == state_ff) ? cnt_ff + 16'h0001 : 16'h0000;
            if (req_take) begin
                req_ff <= i_req;
                cyc_ff <= 3'h0;
            end else if (state_ff == FSS_WHOLD && !last_cycle) begin
                cyc_ff <= cyc_ff + 3'h1;
            end
        end
    end

    // Status capture from reads
    wire logic rd_cap;
    assign rd_cap = (state_ff == FSS_RPULSE) && strobe_done;
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rdata_ff <= 16'h0000;
            poll_prev_ff <= 16'h0000;
            fail_ff <= 1'b0;
            supply_ff <= 1'b0;
            locked_ff <= 1'b0;
            susp_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= (state_ff == FSS_FINISH);
            if (rd_cap) begin
                rdata_ff <= i_dq;
                if (req_ff.op == FSS_OP_POLL) begin
                    // Failure flag follows each poll read; polling is re-read by the user  see [RULE20] see [RULE22]
                    poll_prev_ff <= i_dq;
                    fail_ff <= i_dq[FAILURE_FLAG]; // see [RULE24]
                    supply_ff <= i_dq[SUPPLY_LOW_FLAG]; // see [RULE21]
                end
                if (req_ff.addr[11:0] == ADDR_LOCKSTAT) begin
                    locked_ff <= !i_dq[LOCK_STATE_BIT]; // see [RULE12]
                end
            end
            if (state_ff == FSS_FINISH) begin
                if (req_ff.op == FSS_OP_SUSPEND) begin
                    susp_ff <= 1'b1;
                end else if (req_ff.op == FSS_OP_RESUME) begin
                    susp_ff <= 1'b0;
                end
                if (req_ff.op == FSS_OP_ID_LEAVE) begin
                    fail_ff <= 1'b0; // see [RULE23] see [RULE24]
                end
            end
        end
    end

    // Bus pins: write strobe only with output enable high  see [RULE16] see [RULE17]
    wire logic in_wr;
    assign in_wr = is_write_op && (state_ff == FSS_WSETUP || state_ff == FSS_WPULSE ||
        state_ff == FSS_WHOLD);
    assign o_bus.ce_n = !(in_wr || state_ff == FSS_RPULSE);
    assign o_bus.we_n = !(state_ff == FSS_WPULSE);
    assign o_bus.oe_n = !(state_ff == FSS_RPULSE);
    assign o_bus.addr = in_wr ? {req_ff.addr[19:12], cyc_addr} : req_ff.addr;
    assign o_bus.dq_o = {8'h00, cyc_data};
    assign o_bus.dq_oe = in_wr;
    assign o_rdata = rdata_ff;
    assign o_done = done_ff;
    assign o_fail = fail_ff;
    assign o_supply_low = supply_ff;
    assign o_locked = locked_ff;

    // Checks
    property p_oe_we_excl;
        @(posedge i_core_clk) disable iff (i_sys_rst) !o_bus.we_n |-> o_bus.oe_n && !o_bus.ce_n;
    endproperty
    a_oe_we_excl: assert property (p_oe_we_excl) else $error("we low with oe low"); // see [RULE16]
    property p_pulse_len;
        @(posedge i_core_clk) disable iff (i_sys_rst)
            $fell(o_bus.we_n) |-> !o_bus.we_n [*2];
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("write pulse short"); // see [RULE17]
    property p_susp_wait;
        @(posedge i_core_clk) disable iff (i_sys_rst)
            (state_ff == FSS_WHOLD && req_ff.op == FSS_OP_SUSPEND) |=> state_ff == FSS_SWAIT;
    endproperty
    a_susp_wait: assert property (p_susp_wait) else $error("no suspend wait"); // see [RULE1]
    property p_lock_data;
        @(posedge i_core_clk) disable iff (i_sys_rst)
            (!o_bus.we_n && req_ff.op == FSS_OP_PREG_LOCK && cyc_ff == 3'd3)
            |-> !o_bus.dq_o[LOCK_STATE_BIT];
    endproperty
    a_lock_data: assert property (p_lock_data) else $error("lock bit set"); // see [RULE11]
    property p_lock_refuse;
        @(posedge i_core_clk) disable iff (i_sys_rst)
            (locked_ff && i_req.op == FSS_OP_PREG_PROG && o_req_ready) |=> state_ff == FSS_IDLE;
    endproperty
    a_lock_refuse: assert property (p_lock_refuse) else $error("locked program taken"); // see [RULE13]
    property p_fail_clear;
        @(posedge i_core_clk) disable iff (i_sys_rst)
            (state_ff == FSS_FINISH && req_ff.op == FSS_OP_ID_LEAVE) |=> !o_fail;
    endproperty
    a_fail_clear: assert property (p_fail_clear) else $error("fail not cleared"); // see [RULE24]
    property p_done;
        @(posedge i_core_clk) disable iff (i_sys_rst) state_ff == FSS_FINISH |=> o_done;
    endproperty
    a_done: assert property (p_done) else $error("done missing"); // see [RULE4]
    property p_single;
        @(posedge i_core_clk) disable iff (i_sys_rst)
            (state_ff == FSS_WHOLD && req_ff.op == FSS_OP_RESUME) |=> state_ff == FSS_FINISH;
    endproperty
    a_single: assert property (p_single) else $error("resume not single"); // see [RULE4]
    c_susp: cover property (@(posedge i_core_clk) state_ff == FSS_SWAIT);
    c_lock: cover property (@(posedge i_core_clk) locked_ff);
    c_fail: cover property (@(posedge i_core_clk) o_fail);
endmodule

/* tb/fss_flash_model.sv */
// Behavioural flash device: command decode, ident mode, protection register, status.
// Assumes the host bus struct of the package; dq resolution is done by the bench.
`timescale 1ns/1ps
module fss_flash_model
    import fss_pkg::*;
#(
    parameter logic [15:0] MAKER_CODE = 16'h00a5, // Arbitrary value
    parameter logic [15:0] PART_CODE = 16'h0c3c // Arbitrary value
) (
    // Host side pins
    input wire fss_bus_s i_bus,
    // Fault injection from the bench
    input wire logic i_fault,
    input wire logic i_vpp_low,
    // Lines back to the host
    output logic [15:0] o_dq,
    output logic o_rdy_busy
);
    logic [1:0] seq = 2'd0; // Unlock cycles seen
    logic ident = 1'b0; // Ident mode
    logic lock_n = 1'b1; // User half still programmable
    logic stat = 1'b0; // Sticky status mode
    logic busy = 1'b0; // Internal cycle running
    logic susp = 1'b0; // Operation halted
    logic [15:0] ureg [4] = '{default: 16'h0}; // User half
    logic [15:0] rd; // Word the array would drive
    logic [15:0] last = 16'h0; // Last driven word
    int n_susp = 0; // Suspend commands seen
    int n_res = 0; // Resume commands seen
    realtime t_fall = 0.0; // Strobe fall time
    wire [11:0] a12 = i_bus.addr[11:0];
    wire [7:0] a8 = i_bus.addr[7:0];
    wire [7:0] d8 = i_bus.dq_o[7:0];
    // Noise filter needs the fall time of the write strobe
    always @(negedge i_bus.we_n) t_fall = $realtime;
    // Cycle latched at strobe rise; glitches and output-enabled cycles ignored
    always @(posedge i_bus.we_n) begin
        if (!i_bus.ce_n && i_bus.oe_n && ($realtime - t_fall) >= 15.0) begin
            if (seq == 2'd0) begin
                seq = (a12 == ADDR_UNLOCK1 && d8 == DAT_AA) ? 2'd1 : 2'd0;
                if (d8 == DAT_SUSPEND) begin
                    n_susp++;
                    susp <= #14000 1'b1;
                end
                if (d8 == DAT_RESUME) begin
                    n_res++;
                    susp = 1'b0;
                end
                if (d8 == DAT_IDENT_LEAVE) begin
                    {ident, stat} = 2'b00;
                end
            end else if (seq == 2'd1) begin
                seq = (a12 == ADDR_UNLOCK2 && d8 == DAT_55) ? 2'd2 : 2'd0;
            end else if (seq == 2'd2) begin
                seq = (d8 == DAT_PREG) ? 2'd3 : 2'd0;
                if (d8 == DAT_IDENT_ENTER) ident = 1'b1;
                if (d8 == DAT_IDENT_LEAVE) {ident, stat} = 2'b00;
            end else begin
                seq = 2'd0;
                busy = 1'b1;
                busy <= #300 1'b0;
                if (a8 == 8'h80 && !i_bus.dq_o[1]) begin
                    lock_n = 1'b0;
                end else if (lock_n && a8 >= 8'h85 && a8 <= 8'h88) begin
                    ureg[2'(a8[1:0] - 2'd1)] = i_bus.dq_o;
                end
            end
        end
    end
    // A failed operation leaves the part in status mode
    always @(posedge i_fault) stat = 1'b1;
    // Read word by mode
    always_comb begin
        if (stat) begin
            rd = {10'h0, 1'b1, 1'b0, i_vpp_low, 3'b0};
        end else if (ident) begin
            case (a8)
                8'h00: rd = MAKER_CODE;
                8'h01: rd = PART_CODE;
                8'h80: rd = {14'h0, lock_n, 1'b0};
                8'h81, 8'h82, 8'h83, 8'h84: rd = 16'hfa00 | 16'(a8);
                8'h85, 8'h86, 8'h87, 8'h88: rd = ureg[2'(a8[1:0] - 2'd1)];
                default: rd = 16'h0;
            endcase
        end else begin
            rd = i_bus.addr[15:0] ^ 16'h5a5a;
        end
    end
    // Released bus shows the inverse, so stale data cannot pass
    always @(posedge i_bus.oe_n) last = rd;
    always_comb o_dq = (!i_bus.ce_n && !i_bus.oe_n) ? rd : ~last;
    assign o_rdy_busy = !busy;
endmodule

/* tb/tb_top.sv */
// Self-checking bench: host controller against the flash device model.
// Assumes the package and model; 40 MHz clock, reset held 12 cycles.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
    import fss_pkg::*;
    logic i_core_clk = 1'b0; // Core clock
    logic i_sys_rst = 1'b1; // Reset
    logic i_req_valid = 1'b0; // Request level
    fss_req_s i_req = '0; // Request body
    logic erase_act = 1'b0; // User erase flag
    logic fault = 1'b0; // Model fault
    logic vpp_low = 1'b0; // Model weak supply
    logic o_req_ready, o_done, o_fail, o_supply_low, o_locked, o_erase_blocked, rdy_busy;
    logic [15:0] o_rdata, dq_dev, i_dq;
    fss_bus_s o_bus;
    int mismatches = 0;
    int checks_done = 0;
    int cyc = 0;
    logic [31:0] seed = 32'hc715c3fb; // Fixed seed
    logic ok; // Done seen for last request
    logic [15:0] uval [4]; // Written user words
    logic [19:0] a;
    // Host drives dq only while its enable is up
    assign i_dq = o_bus.dq_oe ? o_bus.dq_o : dq_dev;
    fss_host #(.STROBE_CYCLES(2), .SUSPEND_CYCLES(4)) dut (.i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst), .i_req_valid(i_req_valid), .i_req(i_req),
        .o_req_ready(o_req_ready), .o_done(o_done), .o_rdata(o_rdata), .o_fail(o_fail),
        .o_supply_low(o_supply_low), .o_locked(o_locked), .o_erase_blocked(o_erase_blocked),
        .i_erase_active(erase_act), .o_bus(o_bus), .i_dq(i_dq), .i_rdy_busy(rdy_busy));
    fss_flash_model dev (.i_bus(o_bus), .i_fault(fault), .i_vpp_low(vpp_low),
        .o_dq(dq_dev), .o_rdy_busy(rdy_busy));
    always #12.5 i_core_clk = ~i_core_clk;
    // Xorshift step
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Expected plain array word
    function automatic logic [15:0] exp_mem(input logic [19:0] ad);
        return ad[15:0] ^ 16'h5a5a;
    endfunction
    // One request; refused if ready never drops within 8 cycles
    task automatic run(input fss_op_e op, input logic [19:0] ad, input logic [15:0] d);
        int n;
        ok = 1'b0;
        @(posedge i_core_clk);
        i_req_valid <= 1'b1;
        i_req <= '{op: op, addr: ad, data: d};
        for (n = 0; n < 8; n++) begin
            @(negedge i_core_clk);
            if (o_req_ready !== 1'b1) break;
        end
        @(posedge i_core_clk);
        i_req_valid <= 1'b0;
        for (n = 0; n < 200 && !ok; n++) begin
            @(negedge i_core_clk);
            ok = (o_done === 1'b1);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            give_verdict();
        end
    end
    initial begin
        repeat (6) @(negedge i_core_clk);
        `CHK("ready_rst", 1'b1, o_req_ready)
        `CHK("we_idle", 1'b1, o_bus.we_n)
        `CHK("dq_oe_idle", 1'b0, o_bus.dq_oe)
        repeat (6) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        // Suspend and resume while the user has an erase open
        erase_act <= 1'b1;
        run(FSS_OP_SUSPEND, 20'h0, 16'h0);
        `CHK("susp_done", 1'b1, ok)
        `CHK("susp_cnt", 1, dev.n_susp)
        `CHK("blocked", 1'b1, o_erase_blocked)
        run(FSS_OP_RESUME, 20'h0, 16'h0);
        `CHK("res_cnt", 1, dev.n_res)
        `CHK("unblocked", 1'b0, o_erase_blocked)
        $display("suspend test done");
        // Ident mode: maker code, factory half, user half
        run(FSS_OP_ID_ENTER, 20'h0, 16'h0);
        run(FSS_OP_READ, 20'h0, 16'h0);
        `CHK("maker", 16'h00a5, o_rdata)
        run(FSS_OP_READ, 20'h080, 16'h0);
        `CHK("lock_open", 1'b1, o_rdata[LOCK_STATE_BIT])
        `CHK("locked0", 1'b0, o_locked)
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            uval[i] = seed[15:0];
            run(FSS_OP_PREG_PROG, 20'h085 + 20'(i), uval[i]);
            run(FSS_OP_READ, 20'h085 + 20'(i), 16'h0);
            // Command cycles carry only the low byte
            `CHK("user_word", {8'h00, uval[i][7:0]}, o_rdata)
            a = 20'h081 + 20'(seed[17:16]);
            run(FSS_OP_READ, a, 16'h0);
            `CHK("factory", 16'hfa00 | a[15:0], o_rdata)
        end
        run(FSS_OP_PREG_PROG, 20'h081, 16'h0);
        run(FSS_OP_READ, 20'h081, 16'h0);
        `CHK("factory_fixed", 16'hfa81, o_rdata)
        $display("protection register test done");
        // Lock user half, then try to overwrite it
        run(FSS_OP_PREG_LOCK, 20'h080, seed[31:16]);
        run(FSS_OP_READ, 20'h080, 16'h0);
        `CHK("lock_bit", 1'b0, o_rdata[LOCK_STATE_BIT])
        `CHK("locked1", 1'b1, o_locked)
        run(FSS_OP_PREG_PROG, 20'h085, ~uval[0]);
        `CHK("refused", 1'b0, ok)
        run(FSS_OP_READ, 20'h085, 16'h0);
        `CHK("user_kept", {8'h00, uval[0][7:0]}, o_rdata)
        $display("lock test done");
        // Leave ident mode, random array reads
        run(FSS_OP_ID_LEAVE, 20'h0, 16'h0);
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            run(FSS_OP_READ, seed[19:0], 16'h0);
            `CHK("array", exp_mem(seed[19:0]), o_rdata)
        end
        $display("read test done");
        // Failure with weak supply, status sticks until leave
        vpp_low <= 1'b1;
        fault <= 1'b1;
        run(FSS_OP_POLL, 20'h0, 16'h0);
        `CHK("fail", 1'b1, o_fail)
        `CHK("supply_low", 1'b1, o_supply_low)
        // Poll once more after the failure flag, as a careful host must
        run(FSS_OP_POLL, 20'h0, 16'h0);
        `CHK("fail_recheck", 1'b1, o_fail)
        run(FSS_OP_READ, 20'h00123, 16'h0);
        `CHK("status_stuck", 16'h0028, o_rdata)
        run(FSS_OP_ID_LEAVE, 20'h0, 16'h0);
        `CHK("fail_clr", 1'b0, o_fail)
        run(FSS_OP_READ, 20'h00123, 16'h0);
        `CHK("back_read", exp_mem(20'h00123), o_rdata)
        $display("failure test done");
        give_verdict();
    end
endmodule
